/* hw/csh_defines.vh */
// Timing constants for the configuration status handshake block
`ifndef CSH_DEFINES_VH
`define CSH_DEFINES_VH

// Clock period in picoseconds (125 MHz)
`define CSH_CLK_PERIOD_PS 8000
// Power-on-reset intervals in microseconds
`define CSH_POR_SHORT_US 2000
`define CSH_POR_LONG_US 100000
// Cycle counts derived from the intervals; cycles per microsecond come first so
// the long interval stays inside 32-bit arithmetic
`define CSH_CYC_PER_US (1000000 / `CSH_CLK_PERIOD_PS)
`define CSH_POR_SHORT_CYC (`CSH_POR_SHORT_US * `CSH_CYC_PER_US)
`define CSH_POR_LONG_CYC (`CSH_POR_LONG_US * `CSH_CYC_PER_US)
// Width of the power-on-reset counter
`define CSH_POR_CNT_W 24
// Counter reset value
`define CSH_POR_CNT_RST 24'h00_0000
// Initialization cycles before user mode
`define CSH_INIT_CYC 16
// Counts after our own release during which the status readback is not trusted
`define CSH_STATUS_GUARD_CYC 24'h00_0003

`endif

/* hw/csh_sync2.v */
// Two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module csh_sync2 #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Level
    input wire async_in,
    output reg sync_out
);
    reg meta_r;

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // csh_sync2

/* hw/csh_config_status_handshake.v */
// Status, done and chip-enable handshake of a device during configuration
//
// Operation
// - Status line held low after power-up until the power-on interval elapses.
// - An internal error during configuration pulls the status line low.
// - Status seen low from outside during configuration or initialization means error.
// - In user mode status line transitions are ignored; no reconfiguration.
// - Done line held low from before configuration until configuration ends.
// - Done line released once all data arrived cleanly, before initialization starts.
// - Initialization and user mode only after done line is sensed high.
// - External low on done line in user mode has no effect.
// - Configuration accepted only while chip select is low.
// - Reconfig request low in user mode resets and floats I/O; high restarts.
// - Power-on interval about 2 ms when select high, 100 ms when low.
// - Chain select output driven low once own configuration completes.
`timescale 1ns/100ps
`include "csh_defines.vh"
module csh_config_status_handshake #(
    parameter POR_SHORT_CYC = `CSH_POR_SHORT_CYC,
    parameter POR_LONG_CYC = `CSH_POR_LONG_CYC,
    parameter INIT_CYC = `CSH_INIT_CYC
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Pins from outside
    input wire power_on_delay_select_in,
    input wire reconfig_request_n_in,
    input wire chip_select_in_n_in,
    // Status open-drain line
    input wire config_error_line_n_in,
    output reg config_error_line_n_out,
    output reg config_error_line_n_oe_out,
    // Done open-drain line
    input wire config_complete_line_in,
    output reg config_complete_line_out,
    output reg config_complete_line_oe_out,
    // Chain select to next device
    output reg chain_select_out_n_out,
    // Loader core
    input wire data_all_received_in,
    input wire data_error_in,
    output reg config_active_out,
    output reg config_error_out,
    output reg io_float_out,
    output reg user_mode_out
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [6:0] ST_POR = 7'b000_0001;
    localparam [6:0] ST_RESET = 7'b000_0010;
    localparam [6:0] ST_CONFIG = 7'b000_0100;
    localparam [6:0] ST_WAITDONE = 7'b000_1000;
    localparam [6:0] ST_INIT = 7'b001_0000;
    localparam [6:0] ST_USER = 7'b010_0000;
    localparam [6:0] ST_ERROR = 7'b100_0000;

    // States in which all data is in and the done line is let go
    function loaded_state;
        input [6:0] st;
        begin
            loaded_state = (st == ST_WAITDONE) || (st == ST_INIT) || (st == ST_USER);
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire por_sel_s;
    wire reconf_n_s;
    wire cs_n_s;
    wire status_n_s;
    wire done_s;

    csh_sync2 #(.RESET_VAL(1'b0)) u_sync_power_on_delay_select (
        .clock_in(clock_in), .rst_in(rst_in),
        .async_in(power_on_delay_select_in), .sync_out(por_sel_s));
    csh_sync2 #(.RESET_VAL(1'b0)) u_sync_reconf (
        .clock_in(clock_in), .rst_in(rst_in),
        .async_in(reconfig_request_n_in), .sync_out(reconf_n_s));
    csh_sync2 #(.RESET_VAL(1'b1)) u_sync_cs (
        .clock_in(clock_in), .rst_in(rst_in),
        .async_in(chip_select_in_n_in), .sync_out(cs_n_s));
    csh_sync2 #(.RESET_VAL(1'b0)) u_sync_status (
        .clock_in(clock_in), .rst_in(rst_in),
        .async_in(config_error_line_n_in), .sync_out(status_n_s));
    csh_sync2 #(.RESET_VAL(1'b0)) u_sync_done (
        .clock_in(clock_in), .rst_in(rst_in),
        .async_in(config_complete_line_in), .sync_out(done_s));

    // ------------------------------------------------------------
    // Power-on interval and initialization counter
    // ------------------------------------------------------------
    reg [6:0] state_r;
    reg [6:0] state_nxt;
    reg [`CSH_POR_CNT_W-1:0] cnt_r;
    reg [`CSH_POR_CNT_W-1:0] cnt_nxt;
    reg status_drive_r;
    reg status_drive_nxt;
    wire [`CSH_POR_CNT_W-1:0] por_limit;
    wire por_done;
    wire init_done;
    // Our own driven low masks the readback; only an outside low counts
    wire ext_status_low;

    assign por_limit = por_sel_s ? POR_SHORT_CYC[`CSH_POR_CNT_W-1:0] :
                                   POR_LONG_CYC[`CSH_POR_CNT_W-1:0];
    assign por_done = (cnt_r >= por_limit - 1'b1);
    assign init_done = (cnt_r >= INIT_CYC[`CSH_POR_CNT_W-1:0] - 1'b1);
    // Sync delay: ignore readback for the cycles our own release takes to show
    assign ext_status_low = !status_n_s && !status_drive_r &&
                            (cnt_r > `CSH_STATUS_GUARD_CYC);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 1'b1;
        status_drive_nxt = status_drive_r;
        case (state_r)
            ST_POR: begin
                status_drive_nxt = 1'b1;
                if (por_done) begin
                    state_nxt = ST_RESET;
                    cnt_nxt = `CSH_POR_CNT_RST;
                end
            end
            ST_RESET: begin
                // Held in reset while the reconfig request is low
                status_drive_nxt = 1'b1;
                cnt_nxt = `CSH_POR_CNT_RST;
                if (reconf_n_s) begin
                    state_nxt = ST_CONFIG;
                    status_drive_nxt = 1'b0;
                end
            end
            ST_CONFIG: begin
                if (!reconf_n_s) begin
                    state_nxt = ST_RESET;
                end else if (data_error_in || ext_status_low) begin
                    state_nxt = ST_ERROR;
                end else if (data_all_received_in && !cs_n_s) begin
                    state_nxt = ST_WAITDONE;
                    cnt_nxt = `CSH_POR_CNT_RST;
                end
            end
            ST_WAITDONE: begin
                if (!reconf_n_s) begin
                    state_nxt = ST_RESET;
                end else if (ext_status_low) begin
                    state_nxt = ST_ERROR;
                end else if (done_s) begin
                    state_nxt = ST_INIT;
                    cnt_nxt = `CSH_POR_CNT_RST;
                end
            end
            ST_INIT: begin
                if (!reconf_n_s) begin
                    state_nxt = ST_RESET;
                end else if (ext_status_low) begin
                    state_nxt = ST_ERROR;
                end else if (init_done) begin
                    state_nxt = ST_USER;
                end
            end
            ST_USER: begin
                // Status and done readbacks are not looked at here
                if (!reconf_n_s) begin
                    state_nxt = ST_RESET;
                end
            end
            ST_ERROR: begin
                status_drive_nxt = 1'b1;
                if (!reconf_n_s) begin
                    state_nxt = ST_RESET;
                end
            end
            default: begin
                state_nxt = ST_POR;
                cnt_nxt = `CSH_POR_CNT_RST;
                status_drive_nxt = 1'b1;
            end
        endcase
        if (state_r == ST_CONFIG || state_r == ST_WAITDONE ||
            state_r == ST_USER || state_r == ST_ERROR) begin
            // Saturate so the readback guard holds without wrapping
            if (cnt_r == {`CSH_POR_CNT_W{1'b1}}) begin
                cnt_nxt = cnt_r;
            end
        end
    end

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_POR;
            cnt_r <= `CSH_POR_CNT_RST;
            status_drive_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            status_drive_r <= status_drive_nxt;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            config_error_line_n_out <= 1'b0;
            config_error_line_n_oe_out <= 1'b1;
            config_complete_line_out <= 1'b0;
            config_complete_line_oe_out <= 1'b1;
            chain_select_out_n_out <= 1'b1;
            config_active_out <= 1'b0;
            config_error_out <= 1'b0;
            io_float_out <= 1'b1;
            user_mode_out <= 1'b0;
        end else begin
            config_error_line_n_out <= 1'b0;
            config_error_line_n_oe_out <= status_drive_nxt;
            config_complete_line_out <= 1'b0;
            // Released once all data is in
            config_complete_line_oe_out <= !loaded_state(state_nxt);
            chain_select_out_n_out <= !loaded_state(state_nxt);
            config_active_out <= (state_nxt == ST_CONFIG) && !cs_n_s;
            config_error_out <= (state_nxt == ST_ERROR);
            io_float_out <= (state_nxt != ST_USER);
            user_mode_out <= (state_nxt == ST_USER);
        end
    end
endmodule // csh_config_status_handshake

/* dv/csh_host_model.sv */
// Behavioural far side: the host's pulls on the two open-drain lines
`timescale 1ns/100ps
module csh_host_model (
    // Device drivers and host pull commands
    input logic dev_status_oe_in,
    input logic dev_done_oe_in,
    input logic pull_status_in,
    input logic pull_done_in,
    // Resolved line levels
    output logic status_line_out,
    output logic done_line_out
);
    // Pull-up wins unless some party sinks the line
    assign status_line_out = !(dev_status_oe_in || pull_status_in);
    assign done_line_out = !(dev_done_oe_in || pull_done_in);
endmodule // csh_host_model

/* dv/csh_props.sv */
// Port checks for the configuration handshake block
`timescale 1ns/100ps
module csh_props #(parameter POR_SHORT_CYC = 20) (
    input logic clock_in, rst_in, reconfig_request_n_in, chip_select_in_n_in,
    input logic config_error_line_n_oe_out, config_complete_line_in,
    input logic config_complete_line_oe_out, chain_select_out_n_out,
    input logic data_all_received_in, data_error_in, config_active_out,
    input logic config_error_out, io_float_out, user_mode_out
);
    logic [23:0] since_r;
    // Wide enough for the real power-on count; saturates so later releases still pass
    always @(posedge clock_in or posedge rst_in)
        if (rst_in) since_r <= 24'h00_0000;
        else if (since_r != 24'hff_ffff) since_r <= since_r + 24'h00_0001;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_por_hold: assert property (
        $fell(config_error_line_n_oe_out) |-> since_r >= POR_SHORT_CYC)
        else $error("status released early");
    a_done_held: assert property (
        config_active_out |-> config_complete_line_oe_out)
        else $error("done line not held low");
    a_done_cause: assert property (
        $fell(config_complete_line_oe_out) |-> $past(data_all_received_in))
        else $error("done released without data");
    a_chip_gate: assert property (
        $fell(config_complete_line_oe_out) |-> !($past(chip_select_in_n_in, 2)
        && $past(chip_select_in_n_in, 3) && $past(chip_select_in_n_in, 4)))
        else $error("loaded while not selected");
    a_init_sensed: assert property (
        $rose(user_mode_out) |-> $past(config_complete_line_in, 16))
        else $error("user mode without done high");
    a_user_hold: assert property (
        user_mode_out && reconfig_request_n_in && $past(reconfig_request_n_in)
        && $past(reconfig_request_n_in, 2) |=> user_mode_out)
        else $error("user mode left without request");
    a_user_pins: assert property (
        user_mode_out |-> !io_float_out && !chain_select_out_n_out)
        else $error("user mode outputs wrong");
    a_error_cause: assert property (
        data_error_in && config_active_out |-> ##[1:2] config_error_out)
        else $error("error not entered");
    a_error_pull: assert property (
        $rose(config_error_out) |=> config_error_line_n_oe_out [*3])
        else $error("status not pulled on error");
    a_float_req: assert property (
        user_mode_out && !reconfig_request_n_in |-> ##[1:4] io_float_out)
        else $error("I/O not floated on request");
endmodule // csh_props
bind csh_config_status_handshake csh_props #(.POR_SHORT_CYC(POR_SHORT_CYC)) u_csh_props (
    .clock_in(clock_in), .rst_in(rst_in), .reconfig_request_n_in(reconfig_request_n_in),
    .chip_select_in_n_in(chip_select_in_n_in), .config_complete_line_in(config_complete_line_in),
    .config_error_line_n_oe_out(config_error_line_n_oe_out),
    .config_complete_line_oe_out(config_complete_line_oe_out),
    .chain_select_out_n_out(chain_select_out_n_out), .data_error_in(data_error_in),
    .data_all_received_in(data_all_received_in), .config_active_out(config_active_out),
    .config_error_out(config_error_out), .io_float_out(io_float_out), .user_mode_out(user_mode_out));

/* dv/tb_config_status_handshake.sv */
// Self-checking bench for the configuration handshake block
`timescale 1ns/100ps
module tb_config_status_handshake;
    logic clock_in = 0, rst_in = 1, por_sel = 1, reconfig_n = 1, cs_n = 0;
    logic data_all = 0, data_err = 0, pull_st = 0, pull_dn = 0;
    logic st_line, dn_line, st_oe, dn_oe, chain_n, active, err, flt, user, st_drv, dn_drv;
    int errors = 0, n_compared = 0;
    always #4 clock_in = ~clock_in;
    csh_config_status_handshake #(.POR_SHORT_CYC(20), .POR_LONG_CYC(40))
        u_csh_config_status_handshake (
        .clock_in(clock_in), .rst_in(rst_in), .power_on_delay_select_in(por_sel),
        .reconfig_request_n_in(reconfig_n), .chip_select_in_n_in(cs_n),
        .config_error_line_n_in(st_line), .config_error_line_n_out(st_drv),
        .config_error_line_n_oe_out(st_oe), .config_complete_line_in(dn_line),
        .config_complete_line_out(dn_drv), .config_complete_line_oe_out(dn_oe),
        .chain_select_out_n_out(chain_n), .data_all_received_in(data_all),
        .data_error_in(data_err), .config_active_out(active), .config_error_out(err),
        .io_float_out(flt), .user_mode_out(user));
    csh_host_model u_csh_host_model (.dev_status_oe_in(st_oe), .dev_done_oe_in(dn_oe),
        .pull_status_in(pull_st), .pull_done_in(pull_dn), .status_line_out(st_line),
        .done_line_out(dn_line));
    task chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task nx(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task power_up(input logic sel, input int min);
        int n;
        @(posedge clock_in);
        rst_in <= 1; por_sel <= sel; data_all <= 0;
        repeat (3) @(posedge clock_in);
        rst_in <= 0;
        nx(1);
        chk("status line", st_line, 0);
        n = 1;
        while (active !== 1'b1 && n < 100) begin nx(1); n++; end
        chk("hold-off", n >= min && n <= min + 8, 1);
        chk("status released", st_line, 1);
        chk("status drive value", st_drv, 0);
        chk("done drive value", dn_drv, 0);
        chk("done line", dn_line, 0);
    endtask
    task configure(input logic cs_late);
        @(posedge clock_in); cs_n <= cs_late;
        repeat (4) @(posedge clock_in);
        data_all <= 1; pull_dn <= 1;
        nx(10);
        chk("done held", dn_oe, cs_late);
        chk("not active", active, 0);
        @(posedge clock_in); cs_n <= 0;
        nx(6);
        chk("done oe", dn_oe, 0);
        chk("chain select", chain_n, 0);
        nx(8);
        // Slow host still sinks done, so initialization must wait
        chk("early user", user, 0);
        @(posedge clock_in); pull_dn <= 0;
        for (int i = 0; i < 40 && user !== 1'b1; i++) nx(1);
        chk("user mode", user, 1);
        chk("io float", flt, 0);
    endtask
    task poke_user;
        @(posedge clock_in); pull_st <= 1; pull_dn <= 1;
        nx(8);
        chk("user kept", user, 1);
        chk("no error", err, 0);
        @(posedge clock_in); pull_st <= 0; pull_dn <= 0;
    endtask
    task reconf;
        @(posedge clock_in); reconfig_n <= 0; data_all <= 0; pull_st <= 0;
        nx(6);
        chk("float", flt, 1);
        chk("user off", user, 0);
        @(posedge clock_in); reconfig_n <= 1;
        for (int i = 0; i < 12 && active !== 1'b1; i++) nx(1);
        chk("restart", active, 1);
        chk("error cleared", err, 0);
    endtask
    task fail(input logic outside);
        nx(8);
        @(posedge clock_in); data_err <= !outside; pull_st <= outside;
        @(posedge clock_in); data_err <= 0;
        for (int i = 0; i < 8 && err !== 1'b1; i++) nx(1);
        chk("error", err, 1);
        nx(2);
        chk("status pulled", st_oe, 1);
        reconf;
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        power_up(1, 20);
        configure(1);
        poke_user;
        reconf;
        fail(0);
        fail(1);
        power_up(0, 40);
        configure(0);
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clock_in);
        errors++;
        report_and_stop;
    end
endmodule // tb_config_status_handshake
